/* design/lin_ctrl_cfg.svh */
`ifndef LIN_CTRL_CFG_SVH
`define LIN_CTRL_CFG_SVH

// Clock period of ref_clk_in
`define LIN_CLK_PERIOD_NS 50
// Least dominant time before a bus wake edge counts
`define LIN_WAKE_DOM_NS 30000
`define LIN_WAKE_DOM_CYCLES ((`LIN_WAKE_DOM_NS + `LIN_CLK_PERIOD_NS - 1) / `LIN_CLK_PERIOD_NS)
// Transmit dominant timeout and bus dominant timeout
`define LIN_TX_TO_US 12000
`define LIN_TX_TO_CYCLES ((`LIN_TX_TO_US * 1000) / `LIN_CLK_PERIOD_NS)
`define LIN_BUS_TO_US 12000
`define LIN_BUS_TO_CYCLES ((`LIN_BUS_TO_US * 1000) / `LIN_CLK_PERIOD_NS)
// Persistence needed before a receive pin mismatch is a fault
`define LIN_RXD_FILTER_CYCLES 16
// Pin levels
`define LIN_DOMINANT 1'h0
`define LIN_RECESSIVE 1'h1

`endif

/* design/lin_ctrl_pkg.sv */
`default_nettype none
package lin_ctrl_pkg;

	typedef enum logic [2:0] {
		DEV_INIT = 3'h0,
		DEV_NORMAL = 3'h1,
		DEV_SLEEP = 3'h2,
		DEV_RESTART = 3'h3,
		DEV_STOP = 3'h4,
		DEV_FAILSAFE = 3'h5,
		DEV_SW_PROG = 3'h6
	} device_mode_type;

	typedef enum logic [2:0] {
		LIN_OFF = 3'h0,
		LIN_WAKE = 3'h1,
		LIN_NORMAL = 3'h2,
		LIN_RX_ONLY = 3'h3,
		LIN_FLASH = 3'h4
	} lin_mode_type;

	typedef struct packed {
		logic valid;
		lin_mode_type mode;
	} mode_cmd_type;

	typedef struct packed {
		logic tx_gnd_short;
		logic bus_clamp;
		logic txd_rxd_short;
		logic rxd_recessive;
		logic bus_wake;
	} diag_type;

endpackage
`default_nettype wire

/* design/hold_timer.sv */
`default_nettype none
module hold_timer #(
	parameter int LIMIT = 16
) (
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	input wire logic level_in,
	output logic expired_out
);
	localparam int W = $clog2(LIMIT + 2);

	generate
		if (LIMIT < 1) begin : g_bad
			$error("hold_timer LIMIT must be at least 1");
		end
	endgenerate

	logic [W-1:0] count;
	logic [W-1:0] next_count;

	// Saturates at LIMIT while the level holds, restarts when it drops
	always_comb begin
		if (!level_in) begin
			next_count = '0;
		end else if (count == W'(LIMIT)) begin
			next_count = count;
		end else begin
			next_count = count + 1'b1;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

	assign expired_out = (count == W'(LIMIT));
endmodule
`default_nettype wire

/* design/lin_transceiver_ctrl.sv */
`include "lin_ctrl_cfg.svh"
`default_nettype none
module lin_transceiver_ctrl #(
	parameter int TX_TIMEOUT_CYCLES = `LIN_TX_TO_CYCLES,
	parameter int BUS_TIMEOUT_CYCLES = `LIN_BUS_TO_CYCLES
) (
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	input wire lin_ctrl_pkg::device_mode_type device_mode_in,
	input wire lin_ctrl_pkg::mode_cmd_type mode_cmd_in,
	input wire logic slope_cmd_valid_in,
	input wire logic slope_cmd_fast_in,
	input wire lin_ctrl_pkg::diag_type diag_clear_in,
	input wire logic clamp_int_mask_in,
	input wire logic wake_int_mask_in,
	input wire logic host_txd_in,
	input wire logic host_rxd_sense_in,
	input wire logic bus_level_in,
	input wire logic overtemp_in,
	output logic host_rxd_out,
	output logic bus_drive_out,
	output logic pullup_en_out,
	output logic slope_fast_out,
	output logic slope_shaping_off_out,
	output lin_ctrl_pkg::lin_mode_type lin_mode_out,
	output lin_ctrl_pkg::diag_type diag_out,
	output logic int_b_out
);
	generate
		if (TX_TIMEOUT_CYCLES < 1 || BUS_TIMEOUT_CYCLES < 1) begin : g_bad
			$error("lin_transceiver_ctrl timeouts must be at least one cycle");
		end
	endgenerate

	// Two-stage synchronisers for pin inputs: txd, rxd sense, bus, overtemp
	localparam int NSYNC = 4;
	logic [NSYNC-1:0] sync_a;
	logic [NSYNC-1:0] sync_b;

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sync_a <= {`LIN_RECESSIVE, `LIN_RECESSIVE, `LIN_RECESSIVE, 1'b0};
			sync_b <= {`LIN_RECESSIVE, `LIN_RECESSIVE, `LIN_RECESSIVE, 1'b0};
		end else begin
			sync_a <= {host_txd_in, host_rxd_sense_in, bus_level_in, overtemp_in};
			sync_b <= sync_a;
		end
	end

	logic txd;
	logic rxd_sense;
	logic bus;
	logic overtemp;
	assign txd = sync_b[3];
	assign rxd_sense = sync_b[2];
	assign bus = sync_b[1];
	assign overtemp = sync_b[0];

	lin_ctrl_pkg::lin_mode_type lin_mode;
	lin_ctrl_pkg::lin_mode_type next_lin_mode;
	lin_ctrl_pkg::device_mode_type dev_prev;
	lin_ctrl_pkg::diag_type diag;
	lin_ctrl_pkg::diag_type next_diag;
	logic slope_fast;
	logic next_slope_fast;
	logic ot_hold;
	logic next_ot_hold;
	logic wake_lock;
	logic next_wake_lock;
	logic wake_rxd_low;
	logic next_wake_rxd_low;
	logic wake_irq;
	logic next_wake_irq;
	logic dom_seen;
	logic next_dom_seen;
	logic txd_prev;
	logic bus_prev;
	logic next_host_rxd;
	logic next_bus_drive;
	logic next_int_b;
	lin_ctrl_pkg::lin_mode_type eff_mode;
	lin_ctrl_pkg::lin_mode_type next_eff_mode;

	logic tx_to_hit;
	logic bus_to_hit;
	logic wake_dom_hit;
	logic rxd_rec_hit;
	logic short_hit;
	logic receiving;

	assign receiving = (eff_mode == lin_ctrl_pkg::LIN_NORMAL) ||
		(eff_mode == lin_ctrl_pkg::LIN_RX_ONLY) || (eff_mode == lin_ctrl_pkg::LIN_FLASH);

	hold_timer #(.LIMIT(TX_TIMEOUT_CYCLES)) u_tx_to (
		.ref_clk_in(ref_clk_in),
		.rst_b_in(rst_b_in),
		.level_in(txd == `LIN_DOMINANT),
		.expired_out(tx_to_hit)
	);

	hold_timer #(.LIMIT(BUS_TIMEOUT_CYCLES)) u_bus_to (
		.ref_clk_in(ref_clk_in),
		.rst_b_in(rst_b_in),
		.level_in(bus == `LIN_DOMINANT),
		.expired_out(bus_to_hit)
	);

	hold_timer #(.LIMIT(`LIN_WAKE_DOM_CYCLES)) u_wake_dom (
		.ref_clk_in(ref_clk_in),
		.rst_b_in(rst_b_in),
		.level_in(eff_mode == lin_ctrl_pkg::LIN_WAKE && bus == `LIN_DOMINANT),
		.expired_out(wake_dom_hit)
	);

	// Receive pin read back high while driven low: stuck recessive
	hold_timer #(.LIMIT(`LIN_RXD_FILTER_CYCLES)) u_rxd_rec (
		.ref_clk_in(ref_clk_in),
		.rst_b_in(rst_b_in),
		.level_in(receiving && host_rxd_out == `LIN_DOMINANT &&
			rxd_sense == `LIN_RECESSIVE),
		.expired_out(rxd_rec_hit)
	);

	// Receive pin pulled low by the transmit pin while driven high
	hold_timer #(.LIMIT(`LIN_RXD_FILTER_CYCLES)) u_short (
		.ref_clk_in(ref_clk_in),
		.rst_b_in(rst_b_in),
		.level_in(receiving && host_rxd_out == `LIN_RECESSIVE &&
			rxd_sense == `LIN_DOMINANT && txd == `LIN_DOMINANT),
		.expired_out(short_hit)
	);

	function automatic logic mode_allowed(lin_ctrl_pkg::device_mode_type dev,
		lin_ctrl_pkg::lin_mode_type m);
		logic ok;
		ok = 1'b0;
		case (dev)
			lin_ctrl_pkg::DEV_INIT: ok = (m == lin_ctrl_pkg::LIN_OFF);
			lin_ctrl_pkg::DEV_NORMAL: ok = (m != lin_ctrl_pkg::LIN_FLASH);
			lin_ctrl_pkg::DEV_SLEEP,
			lin_ctrl_pkg::DEV_RESTART,
			lin_ctrl_pkg::DEV_STOP: begin
				ok = (m == lin_ctrl_pkg::LIN_OFF) || (m == lin_ctrl_pkg::LIN_WAKE);
			end
			lin_ctrl_pkg::DEV_FAILSAFE: ok = (m == lin_ctrl_pkg::LIN_WAKE);
			lin_ctrl_pkg::DEV_SW_PROG: ok = (m == lin_ctrl_pkg::LIN_FLASH);
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction

	// Mode that a device mode change leaves behind, column kept where it exists
	function automatic lin_ctrl_pkg::lin_mode_type auto_mode(
		lin_ctrl_pkg::device_mode_type dev, lin_ctrl_pkg::lin_mode_type cur);
		lin_ctrl_pkg::lin_mode_type m;
		m = cur;
		case (dev)
			lin_ctrl_pkg::DEV_INIT: m = lin_ctrl_pkg::LIN_OFF;
			lin_ctrl_pkg::DEV_FAILSAFE: m = lin_ctrl_pkg::LIN_WAKE;
			lin_ctrl_pkg::DEV_SW_PROG: m = lin_ctrl_pkg::LIN_FLASH;
			lin_ctrl_pkg::DEV_NORMAL: begin
				m = (cur == lin_ctrl_pkg::LIN_FLASH) ? lin_ctrl_pkg::LIN_NORMAL : cur;
			end
			lin_ctrl_pkg::DEV_SLEEP,
			lin_ctrl_pkg::DEV_RESTART,
			lin_ctrl_pkg::DEV_STOP: begin
				m = (cur == lin_ctrl_pkg::LIN_WAKE) ? lin_ctrl_pkg::LIN_WAKE :
					lin_ctrl_pkg::LIN_OFF;
			end
			default: m = lin_ctrl_pkg::LIN_OFF;
		endcase
		return m;
	endfunction

	always_comb begin
		logic txd_rise;
		logic bus_rise;
		logic fault;
		logic wake_event;
		txd_rise = (txd_prev == `LIN_DOMINANT) && (txd == `LIN_RECESSIVE);
		bus_rise = (bus_prev == `LIN_DOMINANT) && (bus == `LIN_RECESSIVE);
		fault = tx_to_hit || bus_to_hit || short_hit || rxd_rec_hit;
		wake_event = 1'b0;

		next_lin_mode = lin_mode;
		next_slope_fast = slope_fast;
		next_wake_lock = wake_lock;
		next_wake_irq = wake_irq;
		next_dom_seen = dom_seen;

		// Wake: long dominant phase, then a rising bus edge
		if (eff_mode != lin_ctrl_pkg::LIN_WAKE) begin
			next_dom_seen = 1'b0;
		end else if (bus_rise) begin
			next_dom_seen = 1'b0;
			wake_event = (dom_seen || wake_dom_hit) && !wake_lock;
		end else if (wake_dom_hit) begin
			next_dom_seen = 1'b1;
		end

		// A command sharing the cycle of a device mode change is dropped
		if (device_mode_in != dev_prev) begin
			next_lin_mode = auto_mode(device_mode_in, lin_mode);
		end else if (mode_cmd_in.valid && mode_allowed(device_mode_in, mode_cmd_in.mode) &&
			!(mode_cmd_in.mode == lin_ctrl_pkg::LIN_WAKE && wake_lock)) begin
			// Normal command also releases a fault-forced receive-only
			next_lin_mode = mode_cmd_in.mode;
			if (mode_cmd_in.mode != lin_ctrl_pkg::LIN_WAKE) begin
				next_wake_lock = 1'b0;
			end
		end

		if (fault && (next_lin_mode == lin_ctrl_pkg::LIN_NORMAL ||
			next_lin_mode == lin_ctrl_pkg::LIN_FLASH) && receiving) begin
			next_lin_mode = lin_ctrl_pkg::LIN_RX_ONLY;
		end

		if (slope_cmd_valid_in && device_mode_in == lin_ctrl_pkg::DEV_NORMAL) begin
			next_slope_fast = slope_cmd_fast_in;
		end

		// Overtemperature holds receive-only with no flag and no interrupt
		if (overtemp) begin
			next_ot_hold = 1'b1;
		end else if (ot_hold && txd_rise) begin
			next_ot_hold = 1'b0;
		end else begin
			next_ot_hold = ot_hold;
		end

		// Sticky diagnostics: a new event wins over a clear in the same cycle
		next_diag = diag & ~diag_clear_in;
		if (tx_to_hit && receiving) begin
			next_diag.tx_gnd_short = 1'b1;
		end
		if (bus_to_hit && receiving) begin
			next_diag.bus_clamp = 1'b1;
		end
		if (short_hit) begin
			next_diag.txd_rxd_short = 1'b1;
		end
		if (rxd_rec_hit) begin
			next_diag.rxd_recessive = 1'b1;
		end

		if (diag_clear_in.bus_wake) begin
			next_wake_irq = 1'b0;
		end
		next_wake_rxd_low = wake_rxd_low && (next_lin_mode == lin_ctrl_pkg::LIN_WAKE);
		if (wake_event) begin
			next_diag.bus_wake = 1'b1;
			next_wake_lock = 1'b1;
			next_wake_rxd_low = 1'b1;
			// Sleep, restart and fail-safe wakes report through the receive pin only
			next_wake_irq = (device_mode_in == lin_ctrl_pkg::DEV_STOP) ||
				(device_mode_in == lin_ctrl_pkg::DEV_NORMAL);
		end

		next_eff_mode = (next_ot_hold && (next_lin_mode == lin_ctrl_pkg::LIN_NORMAL ||
			next_lin_mode == lin_ctrl_pkg::LIN_FLASH)) ? lin_ctrl_pkg::LIN_RX_ONLY :
			next_lin_mode;

		case (next_eff_mode)
			lin_ctrl_pkg::LIN_NORMAL,
			lin_ctrl_pkg::LIN_FLASH: begin
				next_bus_drive = (txd == `LIN_DOMINANT);
				next_host_rxd = bus;
			end
			lin_ctrl_pkg::LIN_RX_ONLY: begin
				next_bus_drive = 1'b0;
				next_host_rxd = bus;
			end
			lin_ctrl_pkg::LIN_WAKE: begin
				next_bus_drive = 1'b0;
				next_host_rxd = next_wake_rxd_low ? `LIN_DOMINANT : `LIN_RECESSIVE;
			end
			default: begin
				next_bus_drive = 1'b0;
				next_host_rxd = `LIN_RECESSIVE;
			end
		endcase

		next_int_b = !((next_diag.bus_clamp && !clamp_int_mask_in) ||
			(next_wake_irq && next_diag.bus_wake && !wake_int_mask_in));
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			lin_mode <= lin_ctrl_pkg::LIN_OFF;
			eff_mode <= lin_ctrl_pkg::LIN_OFF;
			dev_prev <= lin_ctrl_pkg::DEV_INIT;
			diag <= '0;
			slope_fast <= 1'b0;
			ot_hold <= 1'b0;
			wake_lock <= 1'b0;
			wake_rxd_low <= 1'b0;
			wake_irq <= 1'b0;
			dom_seen <= 1'b0;
			txd_prev <= `LIN_RECESSIVE;
			bus_prev <= `LIN_RECESSIVE;
			host_rxd_out <= `LIN_RECESSIVE;
			bus_drive_out <= 1'b0;
			pullup_en_out <= 1'b0;
			slope_fast_out <= 1'b0;
			slope_shaping_off_out <= 1'b0;
			lin_mode_out <= lin_ctrl_pkg::LIN_OFF;
			diag_out <= '0;
			int_b_out <= 1'b1;
		end else begin
			lin_mode <= next_lin_mode;
			eff_mode <= next_eff_mode;
			dev_prev <= device_mode_in;
			diag <= next_diag;
			slope_fast <= next_slope_fast;
			ot_hold <= next_ot_hold;
			wake_lock <= next_wake_lock;
			wake_rxd_low <= next_wake_rxd_low;
			wake_irq <= next_wake_irq;
			dom_seen <= next_dom_seen;
			txd_prev <= txd;
			bus_prev <= bus;
			host_rxd_out <= next_host_rxd;
			bus_drive_out <= next_bus_drive;
			pullup_en_out <= (next_eff_mode != lin_ctrl_pkg::LIN_OFF) &&
				(next_eff_mode != lin_ctrl_pkg::LIN_WAKE);
			slope_fast_out <= next_slope_fast;
			slope_shaping_off_out <= (next_eff_mode == lin_ctrl_pkg::LIN_FLASH);
			lin_mode_out <= next_eff_mode;
			diag_out <= next_diag;
			int_b_out <= next_int_b;
		end
	end
endmodule
`default_nettype wire

/* test/lin_bus_model.sv */
`default_nettype none
module lin_bus_model (
	input wire logic drive_in,
	input wire logic force_dom_in,
	input wire logic rxd_pin_in,
	input wire logic rxd_stuck_in,
	input wire logic txd_pin_in,
	input wire logic short_in,
	output logic bus_level_out,
	output logic rxd_sense_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// Wired-AND wire; master termination pulls it recessive once released
	assign bus_level_out = !(drive_in || force_dom_in);
	// Stuck receive pin reads back recessive whatever the cell drives
	// Transmit-receive short drags the receive pin low with a dominant transmit pin
	assign rxd_sense_out = rxd_stuck_in ? 1'h1 : (rxd_pin_in && !(short_in && !txd_pin_in));
endmodule
`default_nettype wire

/* test/lin_ctrl_props.sv */
`default_nettype none
module lin_ctrl_props #(
	parameter int TX_TIMEOUT_CYCLES = 20,
	parameter int BUS_TIMEOUT_CYCLES = 20
) (
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	input wire lin_ctrl_pkg::device_mode_type device_mode_in,
	input wire logic clamp_int_mask_in,
	input wire logic host_rxd_out,
	input wire logic bus_drive_out,
	input wire logic pullup_en_out,
	input wire logic slope_fast_out,
	input wire logic slope_shaping_off_out,
	input wire lin_ctrl_pkg::lin_mode_type lin_mode_out,
	input wire lin_ctrl_pkg::diag_type diag_out,
	input wire logic int_b_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_b_in);
	a_pullup_idle_off: assert property (
		(lin_mode_out inside {lin_ctrl_pkg::LIN_OFF, lin_ctrl_pkg::LIN_WAKE}) |-> !pullup_en_out)
		else $error("pull-up on while off or wake capable");
	a_rxonly_no_drive: assert property (
		lin_mode_out == lin_ctrl_pkg::LIN_RX_ONLY |-> !bus_drive_out)
		else $error("bus driven in receive-only mode");
	a_flash_no_shaping: assert property (
		lin_mode_out == lin_ctrl_pkg::LIN_FLASH |-> slope_shaping_off_out)
		else $error("slope shaping active in flash mode");
	a_init_forces_off: assert property (
		(device_mode_in == lin_ctrl_pkg::DEV_INIT) [*2] |-> lin_mode_out == lin_ctrl_pkg::LIN_OFF)
		else $error("transceiver not off in init mode");
	a_failsafe_wake: assert property (
		(device_mode_in == lin_ctrl_pkg::DEV_FAILSAFE) [*2] |-> lin_mode_out == lin_ctrl_pkg::LIN_WAKE)
		else $error("transceiver not wake capable in fail-safe");
	a_prog_flash: assert property (
		(device_mode_in == lin_ctrl_pkg::DEV_SW_PROG) [*2] |-> lin_mode_out == lin_ctrl_pkg::LIN_FLASH)
		else $error("transceiver not flash in programming mode");
	a_low_power_limit: assert property (
		(device_mode_in inside {lin_ctrl_pkg::DEV_SLEEP, lin_ctrl_pkg::DEV_RESTART,
		lin_ctrl_pkg::DEV_STOP}) [*2]
		|-> lin_mode_out inside {lin_ctrl_pkg::LIN_OFF, lin_ctrl_pkg::LIN_WAKE})
		else $error("transceiver mode outside off or wake in low power mode");
	a_slope_locked: assert property (
		device_mode_in != lin_ctrl_pkg::DEV_NORMAL |=> $stable(slope_fast_out))
		else $error("slope changed outside normal device mode");
	a_clamp_int_low: assert property (
		$rose(diag_out.bus_clamp) && !clamp_int_mask_in |-> ##[0:2] !int_b_out)
		else $error("unmasked bus clamp left interrupt high");
	a_txd_timeout_stop: assert property (
		$rose(diag_out.tx_gnd_short)
		|-> ##[0:1] (lin_mode_out == lin_ctrl_pkg::LIN_RX_ONLY && !bus_drive_out))
		else $error("transmit timeout did not stop the driver");
	a_wake_rxd_low: assert property (
		$rose(diag_out.bus_wake) |-> ##[0:1] !host_rxd_out)
		else $error("bus wake did not pull receive output low");
endmodule
`default_nettype wire

/* test/tb.sv */
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TX_TO = 40;
	localparam int BUS_TO = 60;
	logic ref_clk_in = 1'h0;
	logic rst_b_in = 1'h0;
	lin_ctrl_pkg::device_mode_type device_mode_in = lin_ctrl_pkg::DEV_INIT;
	lin_ctrl_pkg::mode_cmd_type mode_cmd_in = '0;
	lin_ctrl_pkg::diag_type diag_clear_in = '0;
	logic slope_cmd_valid_in = 1'h0;
	logic slope_cmd_fast_in = 1'h0;
	logic clamp_int_mask_in = 1'h0;
	logic wake_int_mask_in = 1'h0;
	logic host_txd_in = 1'h1;
	logic overtemp_in = 1'h0;
	logic force_dom = 1'h0;
	logic rxd_stuck = 1'h0;
	logic rxd_short = 1'h0;
	logic host_rxd_sense_in, bus_level_in, host_rxd_out, bus_drive_out, pullup_en_out;
	logic slope_fast_out, slope_shaping_off_out, int_b_out;
	lin_ctrl_pkg::lin_mode_type lin_mode_out;
	lin_ctrl_pkg::diag_type diag_out;
	int n_mismatch = 0;
	int total_checks = 0;
	int cycles = 0;
	// Rows: device mode, commanded mode, expected mode (codes as in the package)
	logic [2:0] rows [14][3] = '{'{3'h0, 3'h2, 3'h0}, '{3'h1, 3'h2, 3'h2}, '{3'h1, 3'h4, 3'h2},
		'{3'h1, 3'h3, 3'h3}, '{3'h1, 3'h0, 3'h0}, '{3'h1, 3'h1, 3'h1}, '{3'h2, 3'h2, 3'h1},
		'{3'h2, 3'h0, 3'h0}, '{3'h4, 3'h1, 3'h1}, '{3'h3, 3'h2, 3'h1}, '{3'h5, 3'h0, 3'h1},
		'{3'h6, 3'h2, 3'h4}, '{3'h1, 3'h3, 3'h3}, '{3'h1, 3'h2, 3'h2}};

	lin_transceiver_ctrl #(.TX_TIMEOUT_CYCLES(TX_TO), .BUS_TIMEOUT_CYCLES(BUS_TO)) dut_u (
		.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .device_mode_in(device_mode_in),
		.mode_cmd_in(mode_cmd_in), .slope_cmd_valid_in(slope_cmd_valid_in),
		.slope_cmd_fast_in(slope_cmd_fast_in), .diag_clear_in(diag_clear_in),
		.clamp_int_mask_in(clamp_int_mask_in), .wake_int_mask_in(wake_int_mask_in),
		.host_txd_in(host_txd_in), .host_rxd_sense_in(host_rxd_sense_in),
		.bus_level_in(bus_level_in), .overtemp_in(overtemp_in), .host_rxd_out(host_rxd_out),
		.bus_drive_out(bus_drive_out), .pullup_en_out(pullup_en_out),
		.slope_fast_out(slope_fast_out), .slope_shaping_off_out(slope_shaping_off_out),
		.lin_mode_out(lin_mode_out), .diag_out(diag_out), .int_b_out(int_b_out));
	lin_bus_model bus_u (.drive_in(bus_drive_out), .force_dom_in(force_dom),
		.rxd_pin_in(host_rxd_out), .rxd_stuck_in(rxd_stuck), .txd_pin_in(host_txd_in),
		.short_in(rxd_short), .bus_level_out(bus_level_in),
		.rxd_sense_out(host_rxd_sense_in));

	always #25 ref_clk_in = !ref_clk_in;

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_in);
		#5;
	endtask
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic command(input lin_ctrl_pkg::lin_mode_type m);
		mode_cmd_in = '{valid: 1'h1, mode: m};
		tick(1);
		mode_cmd_in = '0;
		tick(2);
	endtask
	task automatic clear_diag;
		diag_clear_in = 5'h1F;
		tick(1);
		diag_clear_in = '0;
		tick(2);
	endtask
	task print_verdict;
		$display("Comparisons %0d, mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	always @(posedge ref_clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_mismatch++;
			print_verdict();
		end
	end

	initial begin
		tick(6);
		check("reset outputs", {host_rxd_out, bus_drive_out, pullup_en_out, slope_fast_out,
			int_b_out, lin_mode_out}, 8'h88);
		check("reset diag", diag_out, 8'h00);
		rst_b_in = 1'h1;
		tick(2);
		slope_cmd_valid_in = 1'h1;
		slope_cmd_fast_in = 1'h1;
		tick(1);
		slope_cmd_valid_in = 1'h0;
		tick(2);
		check("slope in init", slope_fast_out, 8'h00);
		for (int i = 0; i < 14; i++) begin
			device_mode_in = lin_ctrl_pkg::device_mode_type'(rows[i][0]);
			tick(3);
			command(lin_ctrl_pkg::lin_mode_type'(rows[i][1]));
			check("lin mode", lin_mode_out, rows[i][2]);
			check("pull-up", pullup_en_out, rows[i][2] > 3'h1);
			check("shaping off", slope_shaping_off_out, rows[i][2] == 3'h4);
		end
		slope_cmd_valid_in = 1'h1;
		tick(1);
		slope_cmd_valid_in = 1'h0;
		tick(2);
		check("slope in normal", slope_fast_out, 8'h01);
		// Transmit path, then receive-only keeps reception with the driver off
		for (int m = 0; m < 2; m++) begin
			host_txd_in = 1'h0;
			force_dom = m[0];
			tick(8);
			check("drive", bus_drive_out, m == 0);
			check("rxd", host_rxd_out, 8'h00);
			host_txd_in = 1'h1;
			force_dom = 1'h0;
			tick(8);
			command(lin_ctrl_pkg::LIN_RX_ONLY);
		end
		command(lin_ctrl_pkg::LIN_NORMAL);
		host_txd_in = 1'h0;
		tick(TX_TO + 12);
		check("txd timeout flag", diag_out.tx_gnd_short, 8'h01);
		check("txd timeout mode", lin_mode_out, lin_ctrl_pkg::LIN_RX_ONLY);
		check("txd timeout drive", bus_drive_out, 8'h00);
		host_txd_in = 1'h1;
		tick(8);
		check("no self release", lin_mode_out, lin_ctrl_pkg::LIN_RX_ONLY);
		command(lin_ctrl_pkg::LIN_NORMAL);
		check("release by command", lin_mode_out, lin_ctrl_pkg::LIN_NORMAL);
		clear_diag();
		for (int m = 0; m < 2; m++) begin
			clamp_int_mask_in = m[0];
			force_dom = 1'h1;
			tick(BUS_TO + 12);
			check("clamp flag", diag_out.bus_clamp, 8'h01);
			check("clamp mode", lin_mode_out, lin_ctrl_pkg::LIN_RX_ONLY);
			check("clamp int", int_b_out, m == 1);
			force_dom = 1'h0;
			tick(8);
			check("clamp held", lin_mode_out, lin_ctrl_pkg::LIN_RX_ONLY);
			command(lin_ctrl_pkg::LIN_NORMAL);
			check("clamp release", lin_mode_out, lin_ctrl_pkg::LIN_NORMAL);
			clear_diag();
			check("int after clear", int_b_out, 8'h01);
		end
		clamp_int_mask_in = 1'h0;
		host_txd_in = 1'h0;
		overtemp_in = 1'h1;
		tick(6);
		check("hot mode", lin_mode_out, lin_ctrl_pkg::LIN_RX_ONLY);
		check("hot drive", bus_drive_out, 8'h00);
		check("hot silent", {int_b_out, 2'h0, diag_out}, 8'h80);
		overtemp_in = 1'h0;
		tick(5);
		check("cooled waits edge", lin_mode_out, lin_ctrl_pkg::LIN_RX_ONLY);
		host_txd_in = 1'h1;
		tick(6);
		check("edge release", lin_mode_out, lin_ctrl_pkg::LIN_NORMAL);
		rxd_stuck = 1'h1;
		force_dom = 1'h1;
		tick(30);
		check("rxd stuck flag", diag_out.rxd_recessive, 8'h01);
		rxd_stuck = 1'h0;
		force_dom = 1'h0;
		tick(8);
		check("rxd stuck mode", lin_mode_out, lin_ctrl_pkg::LIN_RX_ONLY);
		command(lin_ctrl_pkg::LIN_NORMAL);
		check("rxd stuck release", lin_mode_out, lin_ctrl_pkg::LIN_NORMAL);
		clear_diag();
		command(lin_ctrl_pkg::LIN_RX_ONLY);
		rxd_short = 1'h1;
		host_txd_in = 1'h0;
		tick(24);
		check("short flag", diag_out.txd_rxd_short, 8'h01);
		check("short drive", bus_drive_out, 8'h00);
		host_txd_in = 1'h1;
		rxd_short = 1'h0;
		tick(4);
		command(lin_ctrl_pkg::LIN_NORMAL);
		check("short release", lin_mode_out, lin_ctrl_pkg::LIN_NORMAL);
		clear_diag();
		command(lin_ctrl_pkg::LIN_WAKE);
		device_mode_in = lin_ctrl_pkg::DEV_STOP;
		tick(3);
		force_dom = 1'h1;
		tick(700);
		check("no wake on held bus", diag_out.bus_wake, 8'h00);
		force_dom = 1'h0;
		tick(8);
		check("wake flag", diag_out.bus_wake, 8'h01);
		check("wake rxd int", {host_rxd_out, int_b_out}, 8'h00);
		check("wake mode kept", lin_mode_out, lin_ctrl_pkg::LIN_WAKE);
		clear_diag();
		check("wake int cleared", int_b_out, 8'h01);
		command(lin_ctrl_pkg::LIN_OFF);
		command(lin_ctrl_pkg::LIN_WAKE);
		check("wake rearm", {lin_mode_out, host_rxd_out}, 8'h03);
		print_verdict();
	end
endmodule

bind lin_transceiver_ctrl lin_ctrl_props #(.TX_TIMEOUT_CYCLES(TX_TIMEOUT_CYCLES),
	.BUS_TIMEOUT_CYCLES(BUS_TIMEOUT_CYCLES)) chk_u (.ref_clk_in(ref_clk_in),
	.rst_b_in(rst_b_in), .device_mode_in(device_mode_in), .clamp_int_mask_in(clamp_int_mask_in),
	.host_rxd_out(host_rxd_out), .bus_drive_out(bus_drive_out), .pullup_en_out(pullup_en_out),
	.slope_fast_out(slope_fast_out), .slope_shaping_off_out(slope_shaping_off_out),
	.lin_mode_out(lin_mode_out), .diag_out(diag_out), .int_b_out(int_b_out));
`default_nettype wire
